//--- rtl/bioch_blk_state.sv
// Per-block allocation state table
`timescale 1ns/1ps
`include "bioch_consts.svh"
module bioch_blk_state (
  input  wire logic                          ref_clk,
  input  wire logic                          rst_n,
  input  wire logic                          wr_en,
  input  wire logic                          dealloc_en,
  input  wire logic [`BIOCH_BLK_IDX_W-1:0]   upd_idx,
  input  wire logic [`BIOCH_BLK_IDX_W-1:0]   rd_idx,
  output bioch_pkg::bioch_blk_type           rd_state
);
  // Whole table held in one packed struct
  typedef struct packed {
    bioch_pkg::bioch_blk_type [`BIOCH_NBLK-1:0] blk;
  } bioch_tbl_type;

  bioch_tbl_type st_q;  // Registered table
  bioch_tbl_type st_d;  // Next table

  // Writes mark written; deallocate marks deallocated; reads never touch
  always_comb begin
    st_d = st_q;
    if (wr_en) begin
      st_d.blk[upd_idx] = bioch_pkg::BIOCH_BLK_WRITTEN;
    end else if (dealloc_en) begin
      st_d.blk[upd_idx] = bioch_pkg::BIOCH_BLK_DEALLOC;
    end
  end

  // Table register; all blocks start unwritten
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Lookup path is read only
  assign rd_state = st_q.blk[rd_idx];
endmodule : bioch_blk_state

//--- rtl/bioch_consts.svh
// Constants for the block I/O command handler
`ifndef BIOCH_CONSTS_SVH
`define BIOCH_CONSTS_SVH
`define BIOCH_OPC_FLUSH      8'h00
`define BIOCH_OPC_WRITE      8'h01
`define BIOCH_OPC_READ       8'h02
`define BIOCH_OPC_DSM        8'h09
`define BIOCH_SC_SUCCESS     8'h00
`define BIOCH_SC_INV_OPC     8'h01
`define BIOCH_SC_LBA_RANGE   8'h80
`define BIOCH_SC_CONFLICT    8'h80
`define BIOCH_SC_RO_RANGE    8'h82
`define BIOCH_SC_UNWRITTEN   8'h87
`define BIOCH_SCT_GENERIC    3'h0
`define BIOCH_SCT_CMD        3'h1
`define BIOCH_SCT_MEDIA      3'h2
`define BIOCH_RETRY_BIT      31
`define BIOCH_MEDIA_BIT      30
`define BIOCH_PI_HI          29
`define BIOCH_PI_LO          26
`define BIOCH_COUNT_HI       15
`define BIOCH_COUNT_LO       0
`define BIOCH_DEALLOC_BIT    2
`define BIOCH_DSM_AF_HI      1
`define BIOCH_DSM_AL_HI      5
`define BIOCH_DSM_AL_LO      4
`define BIOCH_NBLK           16
`define BIOCH_BLK_IDX_W      4
`define BIOCH_FLUSH_CYCLES   8'h10
`define BIOCH_PI_ONES        64'hFFFFFFFFFFFFFFFF
`endif

//--- rtl/bioch_pkg.sv
// Types for the block I/O command handler
package bioch_pkg;
  // Per-block allocation state
  typedef enum logic [1:0] {
    BIOCH_BLK_UNWRITTEN = 2'b00,
    BIOCH_BLK_WRITTEN   = 2'b01,
    BIOCH_BLK_DEALLOC   = 2'b10
  } bioch_blk_type;

  // Submitted command as presented at the port
  typedef struct packed {
    logic [7:0]   opcode;
    logic [15:0]  cid;
    logic [63:0]  metadata_pointer;
    logic [127:0] transfer_pointer;
    logic [31:0]  dw10;
    logic [31:0]  dw11;
    logic [31:0]  dw12;
    logic [31:0]  dw13;
    logic         use_sgl;
  } bioch_cmd_type;

  // Decoded read fields
  typedef struct packed {
    logic [63:0]  start_block_address;
    logic [15:0]  block_count_minus_one;
    logic         reduced_retry_flag;
    logic         force_media_read_flag;
    logic [3:0]   protection_action_select;
    logic [63:0]  metadata_pointer;
    logic [127:0] transfer_pointer;
    logic [63:0]  prp1;
    logic [63:0]  prp2;
  } bioch_rd_type;

  // Completion entry posted to the I/O completion queue
  typedef struct packed {
    logic [15:0] cid;
    logic [2:0]  sct;
    logic [7:0]  sc;
  } bioch_cpl_type;

  // Read data beat returned to host side
  typedef struct packed {
    logic [15:0] cid;
    logic [63:0] data;
    logic [63:0] pi;
    logic        last;
  } bioch_beat_type;
endpackage : bioch_pkg

//--- rtl/bioch_read_decode.sv
// Field decoder for the read command words
`timescale 1ns/1ps
`include "bioch_consts.svh"
module bioch_read_decode (
  input  bioch_pkg::bioch_cmd_type cmd,
  output bioch_pkg::bioch_rd_type  rd
);
  // Pure field extraction; reserved bits 25:16 are ignored
  always_comb begin
    rd = '0;
    rd.start_block_address   = {cmd.dw11, cmd.dw10};
    rd.block_count_minus_one =
      cmd.dw12[`BIOCH_COUNT_HI:`BIOCH_COUNT_LO];
    rd.reduced_retry_flag    = cmd.dw12[`BIOCH_RETRY_BIT];
    rd.force_media_read_flag = cmd.dw12[`BIOCH_MEDIA_BIT];
    rd.protection_action_select =
      cmd.dw12[`BIOCH_PI_HI:`BIOCH_PI_LO];
    rd.metadata_pointer      = cmd.metadata_pointer;
    rd.transfer_pointer      = cmd.transfer_pointer;
    // PRP entries only meaningful without SGL
    if (!cmd.use_sgl) begin
      rd.prp1 = cmd.transfer_pointer[63:0];
      rd.prp2 = cmd.transfer_pointer[127:64];
    end
  end
endmodule : bioch_read_decode

//--- rtl/bioch_top.sv
// Block I/O command handler: read, write, dataset management, flush
`timescale 1ns/1ps
`include "bioch_consts.svh"
// Top of the block: sequencer, store,
// allocation table and field decoders
module bioch_top (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  bioch_pkg::bioch_cmd_type   cmd,
  input  wire logic                  cmd_valid,
  output logic                       cmd_ready,
  input  wire logic [63:0]           wr_data,
  input  wire logic                  err_unwritten_supported,
  input  wire logic                  err_unwritten_enabled,
  input  wire logic                  ro_range,
  input  wire logic                  ro_report_en,
  output bioch_pkg::bioch_beat_type  rd_beat,
  output logic                       rd_beat_valid,
  input  wire logic                  rd_beat_ready,
  output bioch_pkg::bioch_rd_type    rd_fields,
  output logic                       media_read,
  output logic                       limited_retry,
  output logic                       flush_active,
  input  wire logic                  flush_done,
  output bioch_pkg::bioch_cpl_type   cpl,
  output logic                       cpl_valid,
  input  wire logic                  cpl_ready
);
  // Controller phases
  // Binary codes written out; the default
  // branch pulls a stray code back to idle
  typedef enum logic [2:0] {
    BIOCH_IDLE  = 3'b000,
    BIOCH_READ  = 3'b001,
    BIOCH_FLUSH = 3'b010,
    BIOCH_CPL   = 3'b011
  } bioch_fsm_type;

  // All controller state in one struct
  // Beat and completion slots are one deep,
  // so a slow host stalls the sequencer
  typedef struct packed {
    bioch_fsm_type            fsm;
    bioch_pkg::bioch_cmd_type cmd;
    logic [15:0]              remain;
    logic [`BIOCH_BLK_IDX_W-1:0] idx;
    bioch_pkg::bioch_beat_type beat;
    logic                     beat_v;
    bioch_pkg::bioch_cpl_type cpl;
    logic                     cpl_v;
    logic [7:0]               flush_cnt;
    logic                     flush_ext;
  } bioch_state_type;

  bioch_state_type s_q;  // Registered state
  bioch_state_type s_d;  // Next state

  // Data store, one word per block
  // Flip-flops: the small table is read
  // in the same cycle it is addressed
  logic [63:0] mem_q [`BIOCH_NBLK];
  logic [63:0] mem_d [`BIOCH_NBLK];

  // Glue between sequencer and helpers
  bioch_pkg::bioch_rd_type  rdec;      // Decoded incoming command
  bioch_pkg::bioch_rd_type  rdec_cur;  // Decoded held command
  bioch_pkg::bioch_blk_type look_st;   // State of block being looked up
  logic                     wr_en;     // Block write this cycle
  logic                     dealloc_en;// Block deallocate this cycle
  logic [`BIOCH_BLK_IDX_W-1:0] upd_idx;
  logic [`BIOCH_BLK_IDX_W-1:0] look_idx;
  logic                     range_bad; // Looked-up block unreadable
  logic                     take;      // Command accepted

  // Two decoders: one looks ahead at the offer,
  // one follows the command being served
  // Decoder for the arriving command, steers admission checks
  bioch_read_decode u_dec_in (
    .cmd (cmd),
    .rd  (rdec)
  );

  // Decoder for the held command, exported to the data mover
  bioch_read_decode u_dec_cur (
    .cmd (s_q.cmd),
    .rd  (rdec_cur)
  );

  // Allocation state table
  // Table update lands on the same edge as the store
  bioch_blk_state u_blk (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .wr_en      (wr_en),
    .dealloc_en (dealloc_en),
    .upd_idx    (upd_idx),
    .rd_idx     (look_idx),
    .rd_state   (look_st)
  );

  // Block index from a start address, wraps on the small table
  // Upper address bits are dropped, so a host
  // must keep its ranges inside the table
  function automatic logic [`BIOCH_BLK_IDX_W-1:0] blk_of(
    input logic [63:0] a
  );
    blk_of = a[`BIOCH_BLK_IDX_W-1:0];
  endfunction : blk_of

  // Conflict check on dataset attributes: a latency hint on a deallocate
  // with no frequency hint in the bits below the deallocate flag is
  // treated as contradictory; coarse but deterministic. The frequency
  // field stays clear of the deallocate flag, else it could never fire
  function automatic logic dsm_conflict(input logic [31:0] attr);
    dsm_conflict = (attr[`BIOCH_DSM_AL_HI:`BIOCH_DSM_AL_LO] != 2'h0) &&
                   (attr[`BIOCH_DSM_AF_HI:0] == 2'h0) &&
                   attr[`BIOCH_DEALLOC_BIT];
  endfunction : dsm_conflict

  // Whole range pre-check for the unwritten error, one block per cycle
  // would cost latency, so admission only samples the start block and
  // the walk re-checks each block as it streams
  // The start block lookup runs before the take,
  // so an early error costs no beat at all
  assign look_idx = (s_q.fsm == BIOCH_READ) ? s_q.idx
                                             : blk_of(rdec.start_block_address);
  assign range_bad = (look_st != bioch_pkg::BIOCH_BLK_WRITTEN);

  // Command ready decodes the phase; valids and
  // beat and completion data come straight from registers
  assign cmd_ready     = (s_q.fsm == BIOCH_IDLE) && !s_q.cpl_v;
  assign take          = cmd_valid && cmd_ready;
  assign rd_beat       = s_q.beat;
  assign rd_beat_valid = s_q.beat_v;
  assign cpl           = s_q.cpl;
  assign cpl_valid     = s_q.cpl_v;
  assign rd_fields     = rdec_cur;
  // Hints stand only while the read streams
  assign media_read    = (s_q.fsm == BIOCH_READ) &&
                         rdec_cur.force_media_read_flag;
  assign limited_retry = (s_q.fsm == BIOCH_READ) &&
                         rdec_cur.reduced_retry_flag;
  assign flush_active  = (s_q.fsm == BIOCH_FLUSH);

  // Next-state logic for the command sequencer
  // One pass picks the next phase, the table
  // update and the store write together
  always_comb begin
    s_d        = s_q;
    wr_en      = 1'b0;
    dealloc_en = 1'b0;
    upd_idx    = blk_of(rdec.start_block_address);
    // Store holds unless a write lands
    for (int i = 0; i < `BIOCH_NBLK; i++) begin
      mem_d[i] = mem_q[i];
    end
    // Beat consumed by host side
    // Cleared first; a new beat set below wins
    if (s_q.beat_v && rd_beat_ready) begin
      s_d.beat_v = 1'b0;
    end
    // Completion taken by queue
    // Cleared first; a new posting below wins
    if (s_q.cpl_v && cpl_ready) begin
      s_d.cpl_v = 1'b0;
    end
    case (s_q.fsm)
      BIOCH_IDLE: begin
        if (take) begin
          // Latch the command; status stays success
          // unless a branch below overrides it
          s_d.cmd        = cmd;
          s_d.cpl.cid    = cmd.cid;
          s_d.cpl.sct    = `BIOCH_SCT_GENERIC;
          s_d.cpl.sc     = `BIOCH_SC_SUCCESS;
          case (cmd.opcode)
            `BIOCH_OPC_WRITE: begin
              // One word per command, written block leaves dealloc
              wr_en = 1'b1;
              // Store and table move on the same edge
              mem_d[upd_idx] = wr_data;
              s_d.fsm = BIOCH_CPL;
            end
            `BIOCH_OPC_READ: begin
              // Error only when supported and enabled;
              // otherwise substitute data is returned
              if (err_unwritten_supported && err_unwritten_enabled &&
                  range_bad) begin
                s_d.cpl.sct = `BIOCH_SCT_MEDIA;
                s_d.cpl.sc  = `BIOCH_SC_UNWRITTEN;
                s_d.fsm     = BIOCH_CPL;
              end else begin
                // Count is zero based, so zero is one block
                s_d.remain = rdec.block_count_minus_one;
                s_d.idx    = blk_of(rdec.start_block_address);
                s_d.fsm    = BIOCH_READ;
              end
            end
            `BIOCH_OPC_DSM: begin
              // Conflict wins over any deallocate asked for
              if (dsm_conflict(cmd.dw11)) begin
                s_d.cpl.sct = `BIOCH_SCT_CMD;
                s_d.cpl.sc  = `BIOCH_SC_CONFLICT;
              end else if (cmd.dw11[`BIOCH_DEALLOC_BIT] && ro_range) begin
                // Optional report; silently skipped when not enabled
                // A refused range leaves the table untouched
                if (ro_report_en) begin
                  s_d.cpl.sct = `BIOCH_SCT_CMD;
                  s_d.cpl.sc  = `BIOCH_SC_RO_RANGE;
                end
              end else if (cmd.dw11[`BIOCH_DEALLOC_BIT]) begin
                // Range start taken from dword 10 as block address
                upd_idx    = blk_of({32'h0, cmd.dw10});
                dealloc_en = 1'b1;
              end
              s_d.fsm = BIOCH_CPL;
            end
            `BIOCH_OPC_FLUSH: begin
              // Command dwords are not looked at
              // Completes once both the minimum wait and media done are in
              s_d.flush_cnt = `BIOCH_FLUSH_CYCLES;
              s_d.flush_ext = 1'b0;
              s_d.fsm       = BIOCH_FLUSH;
            end
            default: begin
              // Unknown opcode completes at once
              s_d.cpl.sc = `BIOCH_SC_INV_OPC;
              s_d.fsm    = BIOCH_CPL;
            end
          endcase
        end
      end
      BIOCH_READ: begin
        // Stream one beat per block while the output slot is free
        // Each block is checked again as it streams,
        // since a range may run into unwritten blocks
        // and the error must end the range there
        if (!s_q.beat_v || rd_beat_ready) begin
          if (err_unwritten_supported && err_unwritten_enabled &&
              range_bad) begin
            // Abort; the rest of the range is skipped
            s_d.cpl.sct = `BIOCH_SCT_MEDIA;
            s_d.cpl.sc  = `BIOCH_SC_UNWRITTEN;
            s_d.fsm     = BIOCH_CPL;
          end else begin
            s_d.beat.cid = s_q.cmd.cid;
            // Non-written blocks return fixed zeros, stable across reads
            s_d.beat.data = range_bad ? 64'h0 : mem_q[s_q.idx];
            s_d.beat.pi   = range_bad ? `BIOCH_PI_ONES : 64'h0;
            // Final block of the range carries last
            s_d.beat.last = (s_q.remain == 16'h0);
            s_d.beat_v    = 1'b1;
            s_d.idx       = s_q.idx + 1'b1;
            s_d.remain    = s_q.remain - 16'h1;
            if (s_q.remain == 16'h0) begin
              s_d.fsm = BIOCH_CPL;
            end
          end
        end
      end
      BIOCH_FLUSH: begin
        // Writes commit on the edge that takes them, so everything completed earlier is
        // already in the store; the wait covers the external media side
        if (flush_done) begin
          s_d.flush_ext = 1'b1;
        end
        // Counter parks at zero
        if (s_q.flush_cnt != 8'h0) begin
          s_d.flush_cnt = s_q.flush_cnt - 8'h1;
        end
        // Flush is global across namespaces, which is allowed
        // Counter and media may finish in either order
        if (s_q.flush_cnt == 8'h0 && (s_q.flush_ext || flush_done)) begin
          s_d.fsm = BIOCH_CPL;
        end
      end
      BIOCH_CPL: begin
        // Wait for last beat to drain before posting
        // so the host sees all data before the status
        if (!s_q.beat_v || rd_beat_ready) begin
          s_d.cpl_v = 1'b1;
          s_d.fsm   = BIOCH_IDLE;
        end
      end
      default: begin
        // Stray phase code falls back to idle
        s_d.fsm = BIOCH_IDLE;
      end
    endcase
  end

  // State register
  // Reset leaves the sequencer idle with both
  // output slots empty
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Data store register, one per block
  // Cleared on reset, so a word never leaks
  // from before the reset into a later read
  genvar g;
  generate
    for (g = 0; g < `BIOCH_NBLK; g++) begin : g_mem
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          mem_q[g] <= 64'h0;
        end else begin
          mem_q[g] <= mem_d[g];
        end
      end
    end
  endgenerate
endmodule : bioch_top

//--- test/bioch_host_sink.sv
// Host-side sink and media model for the command handler
`timescale 1ns/1ps
module bioch_host_sink #(
  parameter int FLUSH_LAT = 20
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic flush_active,
  output logic      rd_beat_ready,
  output logic      cpl_ready,
  output logic      flush_done
);
  logic [1:0] ph_q; // Free-running stall phase
  logic [7:0] fl_q; // Cycles spent in this flush
  // Phase and media delay counters
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_q <= 2'h0;
      fl_q <= 8'h00;
    end else begin
      ph_q <= ph_q + 2'h1;
      // Restart the media delay for every flush
      if (!flush_active) fl_q <= 8'h00;
      else if (fl_q != 8'(FLUSH_LAT)) fl_q <= fl_q + 8'h01;
    end
  end
  // Stall one cycle in four, out of step between the two outputs
  assign rd_beat_ready = (ph_q != 2'h3);
  assign cpl_ready     = (ph_q != 2'h1);
  // Durable after the delay, held until the flush phase ends
  assign flush_done = (fl_q == 8'(FLUSH_LAT));
endmodule : bioch_host_sink

//--- test/bioch_top_asserts.sv
// Port-level checks for the block I/O command handler
`timescale 1ns/1ps
module bioch_top_asserts (
  input wire logic                 ref_clk,
  input wire logic                 rst_n,
  input bioch_pkg::bioch_cmd_type  cmd,
  input wire logic                 cmd_valid,
  input wire logic                 cmd_ready,
  input wire logic                 err_unwritten_enabled,
  input wire logic                 ro_range,
  input wire logic                 ro_report_en,
  input bioch_pkg::bioch_beat_type rd_beat,
  input wire logic                 rd_beat_valid,
  input wire logic                 rd_beat_ready,
  input bioch_pkg::bioch_rd_type   rd_fields,
  input wire logic                 media_read,
  input wire logic                 limited_retry,
  input wire logic                 flush_active,
  input wire logic                 flush_done,
  input bioch_pkg::bioch_cpl_type  cpl,
  input wire logic                 cpl_valid,
  input wire logic                 cpl_ready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Command as offered one edge earlier
  bioch_pkg::bioch_cmd_type cmd_q;
  logic                     take;
  logic                     dsm_del;
  assign take = cmd_valid && cmd_ready;
  assign dsm_del = take && cmd.opcode == 8'h09 && cmd.dw11[2];
  // Snapshot, since decoded fields appear a cycle after the take
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cmd_q <= '0;
    else cmd_q <= cmd;
  end
  // Steps of the checked transfers
  sequence s_conflict;
    dsm_del && cmd.dw11[5:4] != 2'h0 && cmd.dw11[1:0] == 2'h0 && !ro_range;
  endsequence
  sequence s_ro_del;
    dsm_del && cmd.dw11[5:4] == 2'h0 && ro_range && ro_report_en;
  endsequence
  sequence s_flush;
    take && cmd.opcode == 8'h00;
  endsequence
  sequence s_quiet16;
    !cpl_valid[*8] ##1 !cpl_valid[*8];
  endsequence
  sequence s_read;
    take && cmd.opcode == 8'h02 && !err_unwritten_enabled;
  endsequence
  a_cpl_hold: assert property (
    cpl_valid && !cpl_ready |=> cpl_valid && $stable(cpl))
    else $error("completion changed before acceptance");
  a_beat_hold: assert property (
    rd_beat_valid && !rd_beat_ready |=> rd_beat_valid && $stable(rd_beat))
    else $error("read beat changed before acceptance");
  a_conflict_status: assert property (
    s_conflict |-> ##2 cpl_valid && cpl.sct == 3'h1 && cpl.sc == 8'h80)
    else $error("conflicting attributes not reported");
  a_ro_status: assert property (
    s_ro_del |-> ##2 cpl_valid && cpl.sct == 3'h1 && cpl.sc == 8'h82)
    else $error("read-only range not reported");
  a_flush_min: assert property (
    s_flush |=> s_quiet16)
    else $error("flush completed too early");
  a_flush_gate: assert property (
    flush_active && !flush_done |=> !cpl_valid)
    else $error("flush completed before media done");
  a_start_addr: assert property (
    s_read |=> rd_fields.start_block_address == {cmd_q.dw11, cmd_q.dw10}
      && rd_fields.block_count_minus_one == cmd_q.dw12[15:0])
    else $error("start address or count decoded wrongly");
  a_ptr_decode: assert property (
    s_read |=> rd_fields.metadata_pointer == cmd_q.metadata_pointer
      && rd_fields.transfer_pointer == cmd_q.transfer_pointer
      && rd_fields.prp1 == (cmd_q.use_sgl ? 64'h0
                                          : cmd_q.transfer_pointer[63:0])
      && rd_fields.prp2 == (cmd_q.use_sgl ? 64'h0
                                          : cmd_q.transfer_pointer[127:64]))
    else $error("pointer fields decoded wrongly");
  a_read_flags: assert property (
    s_read |=> media_read == cmd_q.dw12[30] && limited_retry == cmd_q.dw12[31]
      && rd_fields.protection_action_select == cmd_q.dw12[29:26])
    else $error("read flags decoded wrongly");
  a_pi_marker: assert property (
    rd_beat_valid && rd_beat.pi != 64'h0 |-> rd_beat.pi == '1
      && rd_beat.data == 64'h0)
    else $error("skip marker with nonzero data");
  a_busy_refuse: assert property (
    cpl_valid |-> !cmd_ready)
    else $error("command accepted with completion pending");
endmodule : bioch_top_asserts
bind bioch_top bioch_top_asserts bioch_top_asserts_inst (.ref_clk, .rst_n,
  .cmd, .cmd_valid, .cmd_ready, .err_unwritten_enabled, .ro_range,
  .ro_report_en, .rd_beat, .rd_beat_valid, .rd_beat_ready, .rd_fields,
  .media_read, .limited_retry, .flush_active, .flush_done, .cpl, .cpl_valid,
  .cpl_ready);

//--- test/tb_block_io_command_handler.sv
// Self-checking bench for the block I/O command handler
`timescale 1ns/1ps
module tb_block_io_command_handler;
  localparam logic [63:0] ONES = '1;
  localparam logic [63:0] D1   = 64'h0123_4567_89AB_CDEF;
  localparam logic [63:0] D2   = 64'h5A5A_0F0F_C3C3_1234;
  logic ref_clk, rst_n, cmd_valid, cmd_ready, rd_beat_valid, rd_beat_ready;
  logic media_read, limited_retry, flush_active, flush_done, cpl_valid;
  logic cpl_ready, ro_range, ro_report_en;
  logic err_unwritten_supported, err_unwritten_enabled;
  logic [63:0]               wr_data;
  bioch_pkg::bioch_cmd_type  cmd;
  bioch_pkg::bioch_beat_type rd_beat;
  bioch_pkg::bioch_rd_type   rd_fields;
  bioch_pkg::bioch_cpl_type  cpl, cs;
  bioch_pkg::bioch_beat_type q_beat[$]; // Accepted beats
  bioch_pkg::bioch_cpl_type  q_cpl[$];  // Accepted completions
  int                        mismatches, checked, took;
  bioch_top bioch_top_inst (.ref_clk, .rst_n, .cmd, .cmd_valid, .cmd_ready,
    .wr_data, .err_unwritten_supported, .err_unwritten_enabled, .ro_range,
    .ro_report_en, .rd_beat, .rd_beat_valid, .rd_beat_ready, .rd_fields,
    .media_read, .limited_retry, .flush_active, .flush_done, .cpl,
    .cpl_valid, .cpl_ready);
  bioch_host_sink bioch_host_sink_inst (.ref_clk, .rst_n, .flush_active,
    .rd_beat_ready, .cpl_ready, .flush_done);
  // 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Collect what the host side accepts
  always @(posedge ref_clk) begin
    if (rst_n && rd_beat_valid && rd_beat_ready) q_beat.push_back(rd_beat);
    if (rst_n && cpl_valid && cpl_ready) q_cpl.push_back(cpl);
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Offer one command, wait for its completion, compare the status
  task automatic run(input logic [7:0] op, input logic [31:0] a, b, c,
                     input logic [63:0] wd, input logic [10:0] st);
    @(posedge ref_clk);
    #1;
    cmd.opcode = op;
    cmd.cid = cmd.cid + 16'h0001;
    cmd.dw10 = a;
    cmd.dw11 = b;
    cmd.dw12 = c;
    wr_data = wd;
    cmd_valid = 1'b1;
    check(cmd_ready, 1'b1);
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    took = 0;
    while (q_cpl.size() == 0 && took < 400) begin
      @(posedge ref_clk);
      took++;
    end
    #1;
    cs = (q_cpl.size() != 0) ? q_cpl.pop_front() : '1;
    check(cs.cid, cmd.cid);
    check({cs.sct, cs.sc}, st);
  endtask : run
  // Compare the next accepted beat
  task automatic beat(input logic [63:0] d, p, input logic l);
    bioch_pkg::bioch_beat_type b;
    b = (q_beat.size() != 0) ? q_beat.pop_front() : '1;
    check(b.data, d);
    check(b.pi, p);
    check(b.last, l);
  endtask : beat
  task automatic wrap_up();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  // Cut a hang short
  initial begin
    #400000;
    mismatches++;
    wrap_up();
  end
  initial begin
    cmd = '0;
    cmd.metadata_pointer = 64'hA5A5_0000_0000_1000;
    cmd.transfer_pointer = {64'h0000_0000_0000_2000, 64'h0000_0000_0000_3000};
    cmd_valid = 1'b0;
    wr_data = 64'h0;
    {err_unwritten_supported, err_unwritten_enabled} = 2'h0;
    {ro_range, ro_report_en} = 2'h0;
    rst_n = 1'b0;
    repeat (20) @(posedge ref_clk);
    #1;
    check(cpl_valid, 1'b0);
    rst_n = 1'b1;
    // Never-written block, then written
    run(8'h02, 32'h3, 32'h0, 32'h0, 64'h0, 11'h000);
    beat(64'h0, ONES, 1'b1);
    run(8'h01, 32'h3, 32'h0, 32'h0, D1, 11'h000);
    run(8'h02, 32'h3, 32'h0, 32'h0, 64'h0, 11'h000);
    beat(D1, 64'h0, 1'b1);
    // Deallocate, then read twice with the same result
    run(8'h09, 32'h3, 32'h4, 32'h0, 64'h0, 11'h000);
    repeat (2) begin
      run(8'h02, 32'h3, 32'h0, 32'h0, 64'h0, 11'h000);
      beat(64'h0, ONES, 1'b1);
    end
    // Rewrite, read back with every flag set
    run(8'h01, 32'h3, 32'h0, 32'h0, D2, 11'h000);
    cmd.use_sgl = 1'b1;
    run(8'h02, 32'h3, 32'h0, 32'hFC00_0000, 64'h0, 11'h000);
    cmd.use_sgl = 1'b0;
    beat(D2, 64'h0, 1'b1);
    // Two blocks from the top index wrap to block zero
    run(8'h02, 32'hF, 32'h0, 32'h1, 64'h0, 11'h000);
    beat(64'h0, ONES, 1'b0);
    beat(64'h0, ONES, 1'b1);
    run(8'h09, 32'h5, 32'h34, 32'h0, 64'h0, 11'h180);
    {ro_range, ro_report_en} = 2'h3;
    run(8'h09, 32'h3, 32'h4, 32'h0, 64'h0, 11'h182);
    {ro_range, ro_report_en} = 2'h0;
    run(8'h02, 32'h3, 32'h0, 32'h0, 64'h0, 11'h000);
    beat(D2, 64'h0, 1'b1);
    // Flush with its reserved fields all set
    run(8'h00, '1, '1, '1, 64'h0, 11'h000);
    check(took >= 20, 1'b1);
    run(8'h7F, 32'h0, 32'h0, 32'h0, 64'h0, 11'h001);
    // Error supported but off, then on
    err_unwritten_supported = 1'b1;
    run(8'h02, 32'h7, 32'h0, 32'h0, 64'h0, 11'h000);
    beat(64'h0, ONES, 1'b1);
    err_unwritten_enabled = 1'b1;
    run(8'h02, 32'h7, 32'h0, 32'h0, 64'h0, 11'h287);
    run(8'h09, 32'h3, 32'h4, 32'h0, 64'h0, 11'h000);
    run(8'h02, 32'h3, 32'h0, 32'h0, 64'h0, 11'h287);
    check(q_beat.size(), 64'h0);
    wrap_up();
  end
endmodule : tb_block_io_command_handler
